// File: rtl/sac_regs.svh
// register map, field positions, reset values and timing counts
// assumes a 10 MHz bus clock and 32-bit AXI4-Lite data
`ifndef SAC_REGS_SVH
`define SAC_REGS_SVH
`define SAC_OFS_CTRL      8'h00
`define SAC_OFS_CFG       8'h04
`define SAC_OFS_STATUS    8'h08
`define SAC_OFS_RESULT    8'h0C
`define SAC_OFS_COMPARE   8'h10
`define SAC_OFS_PIN_MID   8'h14
`define SAC_OFS_PIN_HIGH  8'h18
`define SAC_CTRL_CH_LSB   0
`define SAC_CTRL_CONT     5
`define SAC_CTRL_HWTRG    6
`define SAC_CTRL_IEN      7
`define SAC_CTRL_CMPEN    8
`define SAC_CTRL_CMPGT    9
`define SAC_CFG_CLK_LSB   0
`define SAC_CFG_MODE_LSB  2
`define SAC_CFG_LSMP      4
`define SAC_CFG_DIV_LSB   5
`define SAC_CFG_LPC       7
`define SAC_RST_CTRL      10'h01F
`define SAC_RST_CFG       8'h00
`define SAC_RST_PIN       8'h00
`define SAC_CLK_PERIOD_NS 100
`define SAC_ASYNC_PERIOD_NS 500
`define SAC_ASYNC_HALF_CYC ((`SAC_ASYNC_PERIOD_NS / 2 + `SAC_CLK_PERIOD_NS - 1) / `SAC_CLK_PERIOD_NS)
`define SAC_SAMPLE_SHORT  5'h03
`define SAC_SAMPLE_LONG   5'h17
`endif

// File: rtl/sac_pkg.sv
// types shared by the converter control logic
// assumes sac_regs.svh supplies the numeric constants
package sac_pkg;
  typedef enum logic [3:0] {
    SAC_IDLE    = 4'b0001,
    SAC_SAMPLE  = 4'b0010,
    SAC_CONVERT = 4'b0100,
    SAC_STORE   = 4'b1000
  } sac_state_t;
  typedef enum logic [1:0] {
    SAC_SRC_BUS   = 2'b00,
    SAC_SRC_HALF  = 2'b01,
    SAC_SRC_ALT   = 2'b10,
    SAC_SRC_ASYNC = 2'b11
  } sac_src_t;
  typedef enum logic [1:0] {
    SAC_MODE_8  = 2'b00,
    SAC_MODE_10 = 2'b10
  } sac_mode_t;
endpackage

// File: rtl/sac_top.sv
// successive approximation converter control with AXI4-Lite registers
// assumes synchronous inputs, an external comparator and port pad logic
//
// Operation
// - mid pin register: bits map channels 15..8
// - high pin register: bits map channels 23..16
// - set bit: output hiz, input off, no pullup
// - disabled input reads as zero
// - disabled in reset or channel all ones
// - idle lowest power between conversions
// - raw result 11 or 9 bits
// - round to 10 or 8 bits, place
// - completion flag then interrupt if enabled
// - compare enable checks every result
// - four clock sources, divided; bus default
// - bus clock halved as a source
// - internal async clock generated, running only while selected and converter enabled
// - divider by 1, 2, 4 or 8
// - hardware trigger rising edge starts conversion
// - trigger ignored while converting
// - continuous: only first trigger counts
// - resolution from mode field
// - software or hardware trigger, options supported
// - clock source encoding 00..11
// - mode 00 is 8-bit, 10 is 10-bit
// - divide encoding 1, 2, 4, 8
`timescale 1ns/1ns
`include "sac_regs.svh"
module sac_top
  import sac_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        alternate_clock,
  input  wire logic        hw_trigger_input,
  input  wire logic        sar_cmp_in,
  output logic [10:0]      sar_dac_code,
  output logic             sar_sample,
  output logic             converter_enable,
  output logic             converter_active,
  output logic             low_power_mode,
  output logic             completion_irq,
  input  wire logic [15:0] port_oe_in,
  input  wire logic [15:0] port_pullup_in,
  input  wire logic [15:0] pad_in,
  output logic [15:0]      pad_oe,
  output logic [15:0]      pad_pullup,
  output logic [15:0]      pad_input_enable,
  output logic [15:0]      port_read
);
  logic [4:0]  channel_select;
  logic        continuous;
  logic        hw_trigger_enable;
  logic        completion_irq_enable;
  logic        compare_enable;
  logic        compare_gt;
  logic [1:0]  clock_source_select;
  logic [1:0]  mode;
  logic        long_sample;
  logic [1:0]  clock_divide_select;
  logic        low_power;
  logic [7:0]  analog_pin_disable_mid;
  logic [7:0]  analog_pin_disable_high;
  logic [9:0]  compare_value;
  logic [9:0]  result;
  logic        conversion_complete_flag;
  sac_state_t  state;
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_fire;
  logic        rd_fire;
  logic        ofs_ok;
  logic        disabled;
  logic        abort;
  logic        sw_start;
  logic        hw_start;
  logic [15:0] pin_dis;

  assign pin_dis = {analog_pin_disable_high, analog_pin_disable_mid};
  assign disabled = &channel_select;
  assign converter_enable = ~disabled;
  assign low_power_mode = low_power;

  // pad forcing for analog pins
  assign pad_oe = port_oe_in & ~pin_dis;
  assign pad_pullup = port_pullup_in & ~pin_dis;
  assign pad_input_enable = ~pin_dis;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_read <= 16'h0000;
    end else begin
      port_read <= pad_in & ~pin_dis;
    end
  end

  // ---- AXI4-Lite slave
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_fire = aw_held & w_held & ~s_axi_bvalid;
  assign rd_fire = s_axi_arvalid & s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= ofs_ok ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    case (aw_addr)
      `SAC_OFS_CTRL, `SAC_OFS_CFG, `SAC_OFS_STATUS, `SAC_OFS_RESULT,
      `SAC_OFS_COMPARE, `SAC_OFS_PIN_MID, `SAC_OFS_PIN_HIGH: ofs_ok = 1'b1;
      default: ofs_ok = 1'b0;
    endcase
  end

  // register writes; writes to control, config or compare abort
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {compare_gt, compare_enable, completion_irq_enable,
       hw_trigger_enable, continuous, channel_select} <= `SAC_RST_CTRL;
      {low_power, clock_divide_select, long_sample, mode,
       clock_source_select} <= `SAC_RST_CFG;
      analog_pin_disable_mid <= `SAC_RST_PIN;
      analog_pin_disable_high <= `SAC_RST_PIN;
      compare_value <= 10'h000;
    end else if (wr_fire) begin
      case (aw_addr)
        `SAC_OFS_CTRL: begin
          if (w_strb[0]) begin
            channel_select <= w_data[`SAC_CTRL_CH_LSB +: 5];
            continuous <= w_data[`SAC_CTRL_CONT];
            hw_trigger_enable <= w_data[`SAC_CTRL_HWTRG];
            completion_irq_enable <= w_data[`SAC_CTRL_IEN];
          end
          if (w_strb[1]) begin
            compare_enable <= w_data[`SAC_CTRL_CMPEN];
            compare_gt <= w_data[`SAC_CTRL_CMPGT];
          end
        end
        `SAC_OFS_CFG: begin
          if (w_strb[0]) begin
            clock_source_select <= w_data[`SAC_CFG_CLK_LSB +: 2];
            mode <= w_data[`SAC_CFG_MODE_LSB +: 2];
            long_sample <= w_data[`SAC_CFG_LSMP];
            clock_divide_select <= w_data[`SAC_CFG_DIV_LSB +: 2];
            low_power <= w_data[`SAC_CFG_LPC];
          end
        end
        `SAC_OFS_COMPARE: begin
          if (w_strb[0]) compare_value[7:0] <= w_data[7:0];
          if (w_strb[1]) compare_value[9:8] <= w_data[9:8];
        end
        `SAC_OFS_PIN_MID: begin
          if (w_strb[0]) analog_pin_disable_mid <= w_data[7:0];
        end
        `SAC_OFS_PIN_HIGH: begin
          if (w_strb[0]) analog_pin_disable_high <= w_data[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  assign abort = wr_fire & ((aw_addr == `SAC_OFS_CTRL) | (aw_addr == `SAC_OFS_CFG)
                 | (aw_addr == `SAC_OFS_COMPARE));
  // software start takes the channel value just being written
  assign sw_start = wr_fire & (aw_addr == `SAC_OFS_CTRL) & w_strb[0]
                    & ~(&w_data[`SAC_CTRL_CH_LSB +: 5]) & ~w_data[`SAC_CTRL_HWTRG];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      case (s_axi_araddr)
        `SAC_OFS_CTRL: s_axi_rdata <= {22'h000000, compare_gt, compare_enable,
          completion_irq_enable, hw_trigger_enable, continuous, channel_select};
        `SAC_OFS_CFG: s_axi_rdata <= {24'h000000, low_power, clock_divide_select,
          long_sample, mode, clock_source_select};
        `SAC_OFS_STATUS: s_axi_rdata <= {29'h00000000, disabled,
          ~state[0], conversion_complete_flag};
        `SAC_OFS_RESULT: s_axi_rdata <= {22'h000000, result};
        `SAC_OFS_COMPARE: s_axi_rdata <= {22'h000000, compare_value};
        `SAC_OFS_PIN_MID: s_axi_rdata <= {24'h000000, analog_pin_disable_mid};
        `SAC_OFS_PIN_HIGH: s_axi_rdata <= {24'h000000, analog_pin_disable_high};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---- converter clock: source select then divide
  logic       half_tgl;
  logic       alt_q;
  logic [2:0] async_cnt;
  logic       async_clk;
  logic       async_q;
  logic       src_tick;
  logic [2:0] div_cnt;
  logic [2:0] div_mask;
  logic       conv_tick;
  logic       async_run;

  // internal oscillator runs whenever selected and the channel is not all ones, whatever the power mode
  assign async_run = (clock_source_select == SAC_SRC_ASYNC) & ~disabled;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      half_tgl <= 1'b0;
      alt_q <= 1'b0;
      async_cnt <= 3'h0;
      async_clk <= 1'b0;
      async_q <= 1'b0;
    end else begin
      half_tgl <= ~half_tgl;
      alt_q <= alternate_clock;
      async_q <= async_clk;
      if (!async_run) begin
        async_cnt <= 3'h0;
        async_clk <= 1'b0;
      end else if (async_cnt == 3'(`SAC_ASYNC_HALF_CYC - 1)) begin
        async_cnt <= 3'h0;
        async_clk <= ~async_clk;
      end else begin
        async_cnt <= async_cnt + 3'h1;
      end
    end
  end

  always_comb begin
    case (clock_source_select)
      SAC_SRC_BUS: src_tick = 1'b1;
      SAC_SRC_HALF: src_tick = half_tgl;
      SAC_SRC_ALT: src_tick = alternate_clock & ~alt_q;
      SAC_SRC_ASYNC: src_tick = async_clk & ~async_q;
      default: src_tick = 1'b0;
    endcase
    case (clock_divide_select)
      2'b00: div_mask = 3'h0;
      2'b01: div_mask = 3'h1;
      2'b10: div_mask = 3'h3;
      2'b11: div_mask = 3'h7;
      default: div_mask = 3'h0;
    endcase
  end

  assign conv_tick = src_tick & ((div_cnt & div_mask) == div_mask);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt <= 3'h0;
    end else if (state == SAC_IDLE) begin
      div_cnt <= 3'h0;
    end else if (src_tick) begin
      div_cnt <= div_cnt + 3'h1;
    end
  end

  // ---- hardware trigger
  logic trig_s1;
  logic trig_s2;
  logic trig_s3;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
      trig_s3 <= 1'b0;
    end else begin
      trig_s1 <= hw_trigger_input;
      trig_s2 <= trig_s1;
      trig_s3 <= trig_s2;
    end
  end
  // edges in any busy state, continuous series included, are dropped
  assign hw_start = hw_trigger_enable & trig_s2 & ~trig_s3 & ~disabled
                    & (state == SAC_IDLE) & ~abort;

  // ---- sequencer and successive approximation
  logic [4:0]  samp_cnt;
  logic [10:0] trial;
  logic [10:0] raw;
  logic        mode10;
  logic [9:0]  rounded;
  logic        cmp_true;
  logic [9:0]  cmp_a;
  logic [9:0]  cmp_b;
  logic [9:0]  cmp_diff;
  logic [9:0]  store_val;

  assign mode10 = (mode == SAC_MODE_10);
  assign converter_active = ~state[0];
  assign sar_sample = (state == SAC_SAMPLE);
  assign sar_dac_code = raw;

  always_comb begin
    if (mode10) begin
      rounded = (&raw[10:1]) ? raw[10:1] : raw[10:1] + {9'h000, raw[0]};
    end else begin
      rounded = {2'b00, (&raw[8:1]) ? raw[8:1] : raw[8:1] + {7'h00, raw[0]}};
    end
    cmp_a = mode10 ? rounded : {2'b00, rounded[7:0]};
    cmp_b = mode10 ? compare_value : {2'b00, compare_value[7:0]};
    cmp_true = ~compare_enable | (compare_gt ? (cmp_a >= cmp_b) : (cmp_a < cmp_b));
    cmp_diff = cmp_a - cmp_b;
    // 8-bit difference stays in the low byte
    store_val = compare_enable ? (mode10 ? cmp_diff : {2'b00, cmp_diff[7:0]}) : rounded;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= SAC_IDLE;
      samp_cnt <= 5'h00;
      trial <= 11'h000;
      raw <= 11'h000;
    end else if (disabled || abort) begin
      state <= sw_start ? SAC_SAMPLE : SAC_IDLE;
      samp_cnt <= long_sample ? `SAC_SAMPLE_LONG : `SAC_SAMPLE_SHORT;
      trial <= 11'h000;
      raw <= 11'h000;
    end else begin
      case (state)
        SAC_IDLE: begin
          if (hw_start) begin
            state <= SAC_SAMPLE;
            samp_cnt <= long_sample ? `SAC_SAMPLE_LONG : `SAC_SAMPLE_SHORT;
          end
        end
        SAC_SAMPLE: begin
          if (conv_tick) begin
            if (samp_cnt == 5'h00) begin
              state <= SAC_CONVERT;
              trial <= mode10 ? 11'h400 : 11'h100;
              raw <= mode10 ? 11'h400 : 11'h100;
            end else begin
              samp_cnt <= samp_cnt - 5'h01;
            end
          end
        end
        SAC_CONVERT: begin
          if (conv_tick) begin
            raw <= (sar_cmp_in ? raw : raw & ~trial) | (trial >> 1);
            trial <= trial >> 1;
            if (trial[0]) state <= SAC_STORE;
          end
        end
        SAC_STORE: begin
          samp_cnt <= long_sample ? `SAC_SAMPLE_LONG : `SAC_SAMPLE_SHORT;
          state <= continuous ? SAC_SAMPLE : SAC_IDLE;
        end
        default: state <= SAC_IDLE;
      endcase
    end
  end

  // result and completion flag; a new completion beats a clearing read
  logic store_ok;
  logic flag_clr;
  assign store_ok = (state == SAC_STORE) & cmp_true & ~abort & ~disabled;
  assign flag_clr = rd_fire & (s_axi_araddr == `SAC_OFS_RESULT);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result <= 10'h000;
      conversion_complete_flag <= 1'b0;
    end else begin
      if (store_ok) begin
        result <= store_val;
        conversion_complete_flag <= 1'b1;
      end else if (flag_clr || abort) begin
        conversion_complete_flag <= 1'b0;
      end
    end
  end

  assign completion_irq = conversion_complete_flag & completion_irq_enable;

  // ---- checks
  a_pin_hiz_forced: assert property (@(posedge aclk) disable iff (!aresetn)
    ((pad_oe & pin_dis) == 16'h0000) && ((pad_pullup & pin_dis) == 16'h0000))
    else $error("disabled analog pin still driven or pulled up");
  a_port_read_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> ((port_read & $past(pin_dis)) == 16'h0000))
    else $error("disabled pin reads nonzero");
  a_disabled_goes_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    disabled |-> (state == SAC_IDLE) && !converter_enable)
    else $error("converter active while channel select all ones");
  a_flag_after_store: assert property (@(posedge aclk) disable iff (!aresetn)
    store_ok |=> conversion_complete_flag && (result == $past(store_val)))
    else $error("result or flag missing after store");
  a_irq_follows_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(conversion_complete_flag) && completion_irq_enable |-> completion_irq)
    else $error("completion interrupt missing");
  a_trig_busy_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
    (state != SAC_IDLE) && trig_s2 && !trig_s3 && !abort |-> !hw_start)
    else $error("trigger accepted while converting");
  a_hw_trig_launch: assert property (@(posedge aclk) disable iff (!aresetn)
    hw_start && !disabled |=> (state == SAC_SAMPLE))
    else $error("hardware trigger did not start conversion");
  a_sar_length_8: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(state == SAC_CONVERT) && !mode10 && !abort |-> (trial == 11'h100))
    else $error("8-bit sequence not started at bit 8");
  a_result_8bit_low: assert property (@(posedge aclk) disable iff (!aresetn)
    store_ok && !mode10 |=> (result[9:8] == 2'b00))
    else $error("8-bit result placed in high bits");
  a_tick_divided: assert property (@(posedge aclk) disable iff (!aresetn)
    conv_tick && (clock_divide_select == 2'b11) |-> src_tick && (div_cnt[2:0] == 3'h7))
    else $error("divide by 8 tick misplaced");
endmodule

// File: tb/sac_analog_model.sv
// comparator side of the converter: one fixed analog level on the channel
// assumes the trial code is weighed straight against that level
`timescale 1ns/1ns
module sac_analog_model (
  input  wire logic        aclk,
  input  wire logic [10:0] level,
  input  wire logic [10:0] sar_dac_code,
  input  wire logic        sar_sample,
  output logic             sar_cmp_in
);
  logic junk = 1'h0;
  // no settled decision while sampling
  always @(posedge aclk) junk <= ~junk;
  assign sar_cmp_in = sar_sample ? junk : (level >= sar_dac_code);
endmodule

// File: tb/sar_adc_control_pin_trigger_test.sv
// bench: registers, pin gating, conversions, clock choice, hardware trigger
// assumes sac_top with its register map and the comparator model beside it
`timescale 1ns/1ns
`include "sac_regs.svh"
module sar_adc_control_pin_trigger_test;
  import sac_pkg::*;
  logic        aclk = '0, aresetn = '0, alternate_clock = '0, hw_trigger_input = '0;
  logic [1:0]  alt_div = '0;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0]  s_axi_wstrb = '0;
  logic        s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic        s_axi_arvalid = '0, s_axi_rready = '0;
  logic [15:0] port_oe_in = 16'hFFFF, port_pullup_in = 16'hF0F0, pad_in = 16'h5AFF;
  logic [10:0] level = 11'h2A4;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire  [10:0] sar_dac_code;
  wire         sar_cmp_in, sar_sample, converter_enable, converter_active;
  wire         low_power_mode, completion_irq;
  wire  [15:0] pad_oe, pad_pullup, pad_input_enable, port_read;
  int          miscompares = 0, comparisons = 0, cycles = 0;

  sac_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .alternate_clock, .hw_trigger_input, .sar_cmp_in, .sar_dac_code, .sar_sample,
    .converter_enable, .converter_active, .low_power_mode, .completion_irq, .port_oe_in,
    .port_pullup_in, .pad_in, .pad_oe, .pad_pullup, .pad_input_enable, .port_read);
  sac_analog_model pins (.aclk, .level, .sar_dac_code, .sar_sample, .sar_cmp_in);

  always #50 aclk = ~aclk;
  // alternate source at a quarter of the bus rate
  always @(posedge aclk) begin
    alt_div <= alt_div + 2'h1;
    alternate_clock <= alt_div[1];
  end
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      stop_test;
    end
  end

  task automatic stop_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
    comparisons++;
    if (g < lo || g > hi) begin
      miscompares++;
      $display("wrong value %s expected %0d to %0d seen %0d", nm, lo, hi, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, b;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(negedge aclk);
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'h0;
      if (w) s_axi_wvalid <= 1'h0;
    end while (b !== 1'h1);
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, v;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(negedge aclk);
      ar = s_axi_arvalid & s_axi_arready;
      v = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'h0;
    end while (v !== 1'h1);
    s_axi_rready <= 1'h0;
  endtask
  task automatic w_ok(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk("bresp", 32'h0, r);
  endtask
  task automatic r_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0]  r;
    rd(a, v, r);
    chk("rresp", 32'h0, r);
    chk(nm, e, v);
  endtask
  // cycles spent active by the conversion under way or about to start
  task automatic run_len(output int n);
    n = 0;
    for (int k = 0; k < 400 && converter_active !== 1'h1; k++) @(negedge aclk);
    while (converter_active === 1'h1 && n < 2000) begin
      @(negedge aclk);
      n++;
    end
  endtask

  task automatic t_reset;
    r_chk("ctrl", `SAC_OFS_CTRL, 32'h1F);
    r_chk("cfg", `SAC_OFS_CFG, 32'h0);
    r_chk("mid", `SAC_OFS_PIN_MID, 32'h0);
    r_chk("high", `SAC_OFS_PIN_HIGH, 32'h0);
    r_chk("status", `SAC_OFS_STATUS, 32'h4);
    chk("enable", 32'h0, converter_enable);
    $display("test reset done");
  endtask
  task automatic t_pins;
    logic [15:0] d;
    logic [31:0] v;
    logic [1:0]  r;
    d = 16'h3CA5;
    w_ok(`SAC_OFS_PIN_MID, 32'hA5);
    w_ok(`SAC_OFS_PIN_HIGH, 32'h3C);
    r_chk("mid", `SAC_OFS_PIN_MID, 32'hA5);
    r_chk("high", `SAC_OFS_PIN_HIGH, 32'h3C);
    repeat (2) @(negedge aclk);
    chk("oe", port_oe_in & ~d, pad_oe);
    chk("pullup", port_pullup_in & ~d, pad_pullup);
    chk("in_en", {16'h0, ~d}, pad_input_enable);
    chk("read", pad_in & ~d, port_read);
    wr(8'h40, 32'hFF, r);
    chk("bad wr", 32'h2, r);
    rd(8'h40, v, r);
    chk("bad rd", 32'h2, r);
    chk("bad data", 32'h0, v);
    $display("test pins done");
  endtask
  task automatic t_conv;
    int n;
    logic [31:0] v;
    logic [1:0]  r;
    w_ok(`SAC_OFS_CFG, 32'h88);
    chk("lowpwr", 32'h1, low_power_mode);
    w_ok(`SAC_OFS_CTRL, 32'h83);
    run_len(n);
    chk("active", 32'h0, converter_active);
    chk("irq", 32'h1, completion_irq);
    r_chk("status", `SAC_OFS_STATUS, 32'h1);
    r_chk("result", `SAC_OFS_RESULT, 32'h152);
    repeat (2) @(negedge aclk);
    chk("irq off", 32'h0, completion_irq);
    w_ok(`SAC_OFS_CFG, 32'h60);
    w_ok(`SAC_OFS_CTRL, 32'h03);
    run_len(n);
    chk_rng("8b time", 94, 107, n);
    rd(`SAC_OFS_RESULT, v, r);
    chk("8b high", 32'h0, v[31:8]);
    $display("test conversion done");
  endtask
  task automatic t_clk;
    logic [7:0] c [8] = '{8'h08, 8'h28, 8'h48, 8'h68, 8'h09, 8'h69, 8'h0A, 8'h0B};
    int         f [8] = '{1, 2, 4, 8, 2, 16, 4, 6};
    int         n;
    for (int i = 0; i < 8; i++) begin
      w_ok(`SAC_OFS_CFG, {24'h0, c[i]});
      w_ok(`SAC_OFS_CTRL, 32'h03);
      run_len(n);
      chk_rng("conv time", 14 * f[i] - 2, 15 * f[i] + 3, n);
    end
    $display("test clocks done");
  endtask
  task automatic t_cmp;
    int n;
    w_ok(`SAC_OFS_CFG, 32'h08);
    w_ok(`SAC_OFS_COMPARE, 32'h200);
    w_ok(`SAC_OFS_CTRL, 32'h383);
    run_len(n);
    r_chk("no flag", `SAC_OFS_STATUS, 32'h0);
    w_ok(`SAC_OFS_CTRL, 32'h183);
    run_len(n);
    r_chk("flag", `SAC_OFS_STATUS, 32'h1);
    r_chk("diff", `SAC_OFS_RESULT, 32'h352);
    $display("test compare done");
  endtask
  task automatic t_trig;
    int n;
    w_ok(`SAC_OFS_CTRL, 32'h43);
    repeat (10) @(negedge aclk);
    chk("no start", 32'h0, converter_active);
    @(posedge aclk) hw_trigger_input <= 1'h1;
    run_len(n);
    chk_rng("hw time", 12, 18, n);
    repeat (30) @(negedge aclk);
    chk("one edge", 32'h0, converter_active);
    @(posedge aclk) hw_trigger_input <= 1'h0;
    @(posedge aclk) hw_trigger_input <= 1'h1;
    repeat (8) @(posedge aclk);
    hw_trigger_input <= 1'h0;
    repeat (2) @(posedge aclk);
    // second edge lands mid conversion
    hw_trigger_input <= 1'h1;
    run_len(n);
    repeat (30) @(negedge aclk);
    chk("ignored", 32'h0, converter_active);
    @(posedge aclk) hw_trigger_input <= 1'h0;
    w_ok(`SAC_OFS_CTRL, 32'h63);
    @(posedge aclk) hw_trigger_input <= 1'h1;
    repeat (100) @(negedge aclk);
    chk("cont", 32'h1, converter_active);
    w_ok(`SAC_OFS_CTRL, 32'h1F);
    chk("off", 32'h0, converter_enable);
    chk("idle", 32'h0, converter_active);
    hw_trigger_input <= 1'h0;
    $display("test trigger done");
  endtask

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset;
    t_pins;
    t_conv;
    t_clk;
    t_cmp;
    t_trig;
    stop_test;
  end
endmodule
